// >>> src/fpcs_pkg.sv
// Constants shared by the flash programming command and security block
//
// Behaviour
// - Unused pins held at reset state while programming
// - Self-programming mode: pins behave as halt standby
// - Enter programming mode: attached plus command received
// - Chip erase whole array; block erase one block
// - Write range, then verify stored bytes match
// - Checksum over given address range
// - Blank check whole array and report
// - Every command answered with ACK or NAK
// - Chip-erase prohibition blocks erases; nothing clears ever
// - Chip-erase prohibition alone still allows writes
// - Block-erase prohibition blocks block erase; chip erase clears
// - Write prohibition blocks write, block erase; chip erase clears
// - New security settings apply from next session
// - Shipped state: no prohibition, all commands accepted
// - Only programmer session may set prohibitions
// - Three independent prohibitions, any combination
// - Self-programming ignores prohibitions
// - Commands and responses over asynchronous UART link
`default_nettype none

package fpcs_pkg;

	// ----------------------------------------------------------------
	// Link timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ    = 20_000_000;
	localparam int          BAUD      = 250_000;
	localparam logic [7:0]  BIT_CYC   = 8'(CLK_HZ / BAUD);
	localparam logic [7:0]  HALF_CYC  = 8'(CLK_HZ / BAUD / 2);
	localparam logic [3:0]  TX_BITS   = 4'h9;
	localparam logic [3:0]  RX_STOP   = 4'h9;

	// ----------------------------------------------------------------
	// Flash array geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W    = 12;
	localparam logic [11:0] FLASH_TOP = 12'hFFF;
	localparam int          BLK_SHIFT = 10;
	localparam logic [7:0]  ERASED    = 8'hFF;

	// ----------------------------------------------------------------
	// Command codes, argument counts, responses
	// ----------------------------------------------------------------
	localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h20;
	localparam logic [7:0]  CMD_BLOCK_ERASE = 8'h22;
	localparam logic [7:0]  CMD_WRITE       = 8'h40;
	localparam logic [7:0]  CMD_CHECKSUM    = 8'h13;
	localparam logic [7:0]  CMD_BLANK       = 8'h32;
	localparam logic [7:0]  CMD_SECURITY    = 8'hA0;
	localparam logic [2:0]  ARGS_NONE       = 3'h0;
	localparam logic [2:0]  ARGS_ONE        = 3'h1;
	localparam logic [2:0]  ARGS_RANGE      = 3'h4;
	localparam logic [7:0]  RSP_ACK         = 8'h06;
	localparam logic [7:0]  RSP_NAK         = 8'h15;

	// ----------------------------------------------------------------
	// Security bits and reset values
	// ----------------------------------------------------------------
	localparam int          SEC_CE    = 0;
	localparam int          SEC_BE    = 1;
	localparam int          SEC_WR    = 2;
	localparam logic [2:0]  SEC_KEEP  = 3'h1;
	localparam logic [2:0]  SEC_RESET = 3'h0;

endpackage : fpcs_pkg

`default_nettype wire

// >>> src/fpcs_uart_rx.sv
// Asynchronous serial receiver, 8 data bits, one stop bit
`default_nettype none

module fpcs_uart_rx (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Serial pin
	input  wire logic       rxd,
	// Received byte
	output logic            valid,
	output logic [7:0]      data
);

	logic       s1_r, s2_r;             // Pin synchroniser
	logic       busy_r, busy_nxt;       // Frame in progress
	logic [7:0] cnt_r, cnt_nxt;         // Baud counter
	logic [3:0] bits_r, bits_nxt;       // Bit index, 0 is start
	logic [7:0] shf_r, shf_nxt;         // Data shifter
	logic       valid_nxt;
	logic [7:0] data_nxt;

	// Two flops before any logic reads the pin
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
		end
		else
		begin
			s1_r <= rxd;
			s2_r <= s1_r;
		end
	end

	// Sample each bit in its middle
	always_comb
	begin
		busy_nxt  = busy_r;
		cnt_nxt   = cnt_r;
		bits_nxt  = bits_r;
		shf_nxt   = shf_r;
		valid_nxt = 1'b0;
		data_nxt  = data;
		if (!busy_r)
		begin
			if (!s2_r)
			begin
				busy_nxt = 1'b1;
				cnt_nxt  = fpcs_pkg::HALF_CYC;
				bits_nxt = 4'h0;
			end
		end
		else if (cnt_r != 8'h00)
			cnt_nxt = cnt_r - 8'h01;
		else if (bits_r == 4'h0)
		begin
			// False start bit is dropped
			busy_nxt = !s2_r;
			cnt_nxt  = fpcs_pkg::BIT_CYC;
			bits_nxt = 4'h1;
		end
		else if (bits_r != fpcs_pkg::RX_STOP)
		begin
			shf_nxt  = {s2_r, shf_r[7:1]};
			cnt_nxt  = fpcs_pkg::BIT_CYC;
			bits_nxt = bits_r + 4'h1;
		end
		else
		begin
			// Byte kept only with a good stop bit
			busy_nxt  = 1'b0;
			valid_nxt = s2_r;
			data_nxt  = shf_r;
		end
	end

	// Register the receiver state
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_r <= 1'b0;
			cnt_r  <= 8'h00;
			bits_r <= 4'h0;
			shf_r  <= 8'h00;
			valid  <= 1'b0;
			data   <= 8'h00;
		end
		else
		begin
			busy_r <= busy_nxt;
			cnt_r  <= cnt_nxt;
			bits_r <= bits_nxt;
			shf_r  <= shf_nxt;
			valid  <= valid_nxt;
			data   <= data_nxt;
		end
	end

endmodule : fpcs_uart_rx

`default_nettype wire

// >>> src/fpcs_uart_tx.sv
// Asynchronous serial transmitter, 8 data bits, one stop bit
`default_nettype none

module fpcs_uart_tx (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Byte to send
	input  wire logic       start,
	input  wire logic [7:0] data,
	output logic            busy,
	// Serial pin
	output logic            txd
);

	logic       busy_nxt, txd_nxt;
	logic [7:0] cnt_r, cnt_nxt;         // Baud counter
	logic [3:0] bits_r, bits_nxt;       // Bits still to send
	logic [8:0] shf_r, shf_nxt;         // Data then stop bit

	// Start bit at once, then shift out every bit period
	always_comb
	begin
		busy_nxt = busy;
		txd_nxt  = txd;
		cnt_nxt  = cnt_r;
		bits_nxt = bits_r;
		shf_nxt  = shf_r;
		if (!busy)
		begin
			if (start)
			begin
				busy_nxt = 1'b1;
				txd_nxt  = 1'b0;
				shf_nxt  = {1'b1, data};
				bits_nxt = fpcs_pkg::TX_BITS;
				cnt_nxt  = fpcs_pkg::BIT_CYC;
			end
		end
		else if (cnt_r != 8'h00)
			cnt_nxt = cnt_r - 8'h01;
		else if (bits_r == 4'h0)
			busy_nxt = 1'b0;
		else
		begin
			txd_nxt  = shf_r[0];
			shf_nxt  = {1'b1, shf_r[8:1]};
			bits_nxt = bits_r - 4'h1;
			cnt_nxt  = fpcs_pkg::BIT_CYC;
		end
	end

	// Register the transmitter state; line idles high
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy   <= 1'b0;
			txd    <= 1'b1;
			cnt_r  <= 8'h00;
			bits_r <= 4'h0;
			shf_r  <= 9'h1FF;
		end
		else
		begin
			busy   <= busy_nxt;
			txd    <= txd_nxt;
			cnt_r  <= cnt_nxt;
			bits_r <= bits_nxt;
			shf_r  <= shf_nxt;
		end
	end

endmodule : fpcs_uart_tx

`default_nettype wire

// >>> src/fpcs_cmd.sv
// Flash programming mode command interpreter with security prohibitions
`default_nettype none

module fpcs_cmd (
	// Clock and reset (reset comes only from the programmer)
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Programmer link pins
	input  wire logic        rxd_pin,
	input  wire logic        attach_pin,
	output logic             txd_pin,
	// Mode and pin state
	input  wire logic        self_prog,
	output logic             prog_mode,
	output logic             pins_reset_hold,
	output logic             pins_halt,
	// Flash array port
	output logic [11:0]      fl_addr,
	output logic [7:0]       fl_wdata,
	output logic             fl_rd,
	output logic             fl_wr,
	output logic             fl_erase_chip,
	output logic             fl_erase_block,
	input  wire logic [7:0]  fl_rdata,
	input  wire logic        fl_busy,
	// Nonvolatile security store
	input  wire logic [2:0]  sec_nv,
	output logic             sec_wr,
	output logic [2:0]       sec_wdata
);

	// ----------------------------------------------------------------
	// Types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_ARG, S_DISPATCH, S_BUSY_WAIT, S_SEC_CLR, S_WR_DATA,
		S_RD_ISSUE, S_RD_WAIT, S_RD_USE, S_RESP
	} fpcs_state_type;

	// Argument bytes that follow a command code
	function automatic logic [2:0] fpcs_arg_len(input logic [7:0] cmd);
		case (cmd)
			fpcs_pkg::CMD_BLOCK_ERASE: fpcs_arg_len = fpcs_pkg::ARGS_ONE;
			fpcs_pkg::CMD_SECURITY:    fpcs_arg_len = fpcs_pkg::ARGS_ONE;
			fpcs_pkg::CMD_WRITE:       fpcs_arg_len = fpcs_pkg::ARGS_RANGE;
			fpcs_pkg::CMD_CHECKSUM:    fpcs_arg_len = fpcs_pkg::ARGS_RANGE;
			default:                   fpcs_arg_len = fpcs_pkg::ARGS_NONE;
		endcase
	endfunction : fpcs_arg_len

	// Range lies in the array and runs upward
	function automatic logic fpcs_range_ok(input logic [31:0] rng);
		fpcs_range_ok = (rng[31:28] == 4'h0) && (rng[15:12] == 4'h0)
			&& (rng[27:16] <= rng[11:0]);
	endfunction : fpcs_range_ok

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic           att_s1_r, att_s2_r;         // Attach pin synchroniser
	logic           rx_valid;                   // Byte from programmer
	logic [7:0]     rx_data;
	logic           tx_busy;                    // Transmitter busy
	logic           txd;
	fpcs_state_type state_r, state_nxt;         // Command sequencer
	logic [7:0]     op_r, op_nxt;               // Command in progress
	logic [2:0]     argn_r, argn_nxt;           // Argument bytes left
	logic [31:0]    arg_r, arg_nxt;             // Argument shifter
	logic [11:0]    end_r, end_nxt;             // Last address of range
	logic           err_r, err_nxt;             // Verify or blank miss
	logic [15:0]    sum_r, sum_nxt;             // Checksum accumulator
	logic [15:0]    sum_new;
	logic           last;
	logic [23:0]    rbuf_r, rbuf_nxt;           // Response bytes, MSB first
	logic [1:0]     rn_r, rn_nxt;               // Response bytes left
	logic           tx_start_r, tx_start_nxt;
	logic [7:0]     tx_data_r, tx_data_nxt;
	logic [2:0]     sec_act_r, sec_act_nxt;     // Prohibitions of this session
	logic           mode_nxt, hold_nxt, halt_nxt;
	logic [11:0]    addr_nxt;
	logic [7:0]     wdata_nxt;
	logic           rd_nxt, wr_nxt, ce_nxt, be_nxt;
	logic           sw_nxt;
	logic [2:0]     swd_nxt;

	assign sum_new = sum_r + {8'h00, fl_rdata};
	assign last    = (fl_addr == end_r);

	// ----------------------------------------------------------------
	// Serial link
	// ----------------------------------------------------------------

	// Receiver; it synchronises the pin itself
	fpcs_uart_rx u_rx (
		.clock   (clock),
		.reset_n (reset_n),
		.rxd     (rxd_pin),
		.valid   (rx_valid),
		.data    (rx_data)
	);

	// Transmitter; only ever answers a command
	fpcs_uart_tx u_tx (
		.clock   (clock),
		.reset_n (reset_n),
		.start   (tx_start_r),
		.data    (tx_data_r),
		.busy    (tx_busy),
		.txd     (txd)
	);

	assign txd_pin = txd;

	// Attach pin passes two flops before use
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			att_s1_r <= 1'b0;
			att_s2_r <= 1'b0;
		end
		else
		begin
			att_s1_r <= attach_pin;
			att_s2_r <= att_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------

	// Next state, flash strobes, security writes and responses
	always_comb
	begin
		state_nxt    = state_r;
		op_nxt       = op_r;
		argn_nxt     = argn_r;
		arg_nxt      = arg_r;
		end_nxt      = end_r;
		err_nxt      = err_r;
		sum_nxt      = sum_r;
		rbuf_nxt     = rbuf_r;
		rn_nxt       = rn_r;
		tx_start_nxt = 1'b0;
		tx_data_nxt  = tx_data_r;
		sec_act_nxt  = sec_act_r;
		mode_nxt     = prog_mode;
		addr_nxt     = fl_addr;
		wdata_nxt    = fl_wdata;
		rd_nxt       = 1'b0;
		wr_nxt       = 1'b0;
		ce_nxt       = 1'b0;
		be_nxt       = 1'b0;
		sw_nxt       = 1'b0;
		swd_nxt      = sec_wdata;
		case (state_r)
			// Wait for a command; the programmer always speaks first
			S_IDLE:
			begin
				if (rx_valid && att_s2_r)
				begin
					if (!prog_mode)
					begin
						mode_nxt    = 1'b1;
						sec_act_nxt = sec_nv;
					end
					op_nxt   = rx_data;
					argn_nxt = fpcs_arg_len(rx_data);
					if (fpcs_arg_len(rx_data) == fpcs_pkg::ARGS_NONE)
						state_nxt = S_DISPATCH;
					else
						state_nxt = S_ARG;
				end
			end
			// Collect address, block or security arguments
			S_ARG:
			begin
				if (rx_valid)
				begin
					arg_nxt  = {arg_r[23:0], rx_data};
					argn_nxt = argn_r - 3'h1;
					if (argn_r == 3'h1)
						state_nxt = S_DISPATCH;
				end
			end
			// Check prohibitions, then start the operation
			S_DISPATCH:
			begin
				rbuf_nxt  = {fpcs_pkg::RSP_NAK, 16'h0000};
				rn_nxt    = 2'h1;
				state_nxt = S_RESP;
				case (op_r)
					fpcs_pkg::CMD_CHIP_ERASE:
					begin
						if (!sec_act_r[fpcs_pkg::SEC_CE])
						begin
							ce_nxt    = 1'b1;
							state_nxt = S_BUSY_WAIT;
						end
					end
					fpcs_pkg::CMD_BLOCK_ERASE:
					begin
						if (sec_act_r == fpcs_pkg::SEC_RESET)
						begin
							addr_nxt  = 12'(arg_r[1:0]) << fpcs_pkg::BLK_SHIFT;
							be_nxt    = 1'b1;
							state_nxt = S_BUSY_WAIT;
						end
					end
					fpcs_pkg::CMD_WRITE:
					begin
						// Chip-erase prohibition alone leaves writes open
						if (!sec_act_r[fpcs_pkg::SEC_WR] && fpcs_range_ok(arg_r))
						begin
							addr_nxt  = arg_r[27:16];
							end_nxt   = arg_r[11:0];
							err_nxt   = 1'b0;
							state_nxt = S_WR_DATA;
						end
					end
					fpcs_pkg::CMD_CHECKSUM:
					begin
						if (fpcs_range_ok(arg_r))
						begin
							addr_nxt  = arg_r[27:16];
							end_nxt   = arg_r[11:0];
							sum_nxt   = 16'h0000;
							state_nxt = S_RD_ISSUE;
						end
					end
					fpcs_pkg::CMD_BLANK:
					begin
						addr_nxt  = 12'h000;
						end_nxt   = fpcs_pkg::FLASH_TOP;
						err_nxt   = 1'b0;
						state_nxt = S_RD_ISSUE;
					end
					fpcs_pkg::CMD_SECURITY:
					begin
						// Bits only add; stored value waits for next session
						sw_nxt   = 1'b1;
						swd_nxt  = sec_nv | arg_r[2:0];
						rbuf_nxt = {fpcs_pkg::RSP_ACK, 16'h0000};
					end
					default:
					begin
						rbuf_nxt = {fpcs_pkg::RSP_NAK, 16'h0000};
					end
				endcase
			end
			// Wait for the array to finish a write or an erase
			S_BUSY_WAIT:
			begin
				if (!fl_busy && !wr_or_erase_r())
				begin
					rbuf_nxt = {fpcs_pkg::RSP_ACK, 16'h0000};
					rn_nxt   = 2'h1;
					case (op_r)
						fpcs_pkg::CMD_WRITE:      state_nxt = S_RD_ISSUE;
						fpcs_pkg::CMD_CHIP_ERASE: state_nxt = S_SEC_CLR;
						default:                  state_nxt = S_RESP;
					endcase
				end
			end
			// Successful chip erase lifts block and write prohibitions unless the stored chip-erase bit is set
			S_SEC_CLR:
			begin
				sw_nxt    = 1'b1;
				swd_nxt   = sec_nv[fpcs_pkg::SEC_CE] ? sec_nv
					: (sec_nv & fpcs_pkg::SEC_KEEP);
				state_nxt = S_RESP;
			end
			// Take one data byte and program it
			S_WR_DATA:
			begin
				if (rx_valid)
				begin
					wdata_nxt = rx_data;
					wr_nxt    = 1'b1;
					state_nxt = S_BUSY_WAIT;
				end
			end
			// Read strobe, then wait a cycle for the data
			S_RD_ISSUE:
			begin
				rd_nxt    = 1'b1;
				state_nxt = S_RD_WAIT;
			end
			S_RD_WAIT:
			begin
				state_nxt = S_RD_USE;
			end
			// Use the byte read back
			S_RD_USE:
			begin
				state_nxt = S_RD_ISSUE;
				if (!last)
					addr_nxt = fl_addr + 12'h001;
				case (op_r)
					fpcs_pkg::CMD_WRITE:
					begin
						err_nxt = err_r | (fl_rdata != fl_wdata);
						if (!last)
							state_nxt = S_WR_DATA;
					end
					fpcs_pkg::CMD_CHECKSUM:
					begin
						sum_nxt = sum_new;
					end
					default:
					begin
						err_nxt = err_r | (fl_rdata != fpcs_pkg::ERASED);
					end
				endcase
				if (last)
				begin
					state_nxt = S_RESP;
					rn_nxt    = 2'h1;
					if (op_r == fpcs_pkg::CMD_CHECKSUM)
					begin
						rbuf_nxt = {fpcs_pkg::RSP_ACK, sum_new};
						rn_nxt   = 2'h3;
					end
					else if (err_nxt)
						rbuf_nxt = {fpcs_pkg::RSP_NAK, 16'h0000};
					else
						rbuf_nxt = {fpcs_pkg::RSP_ACK, 16'h0000};
				end
			end
			// Send the response bytes one after another
			S_RESP:
			begin
				if (rn_r == 2'h0)
					state_nxt = S_IDLE;
				else if (!tx_busy && !tx_start_r)
				begin
					tx_start_nxt = 1'b1;
					tx_data_nxt  = rbuf_r[23:16];
					rbuf_nxt     = {rbuf_r[15:0], 8'h00};
					rn_nxt       = rn_r - 2'h1;
				end
			end
			default:
			begin
				state_nxt = S_IDLE;
			end
		endcase
		// Pins idle at reset state in programming mode, halt state in self mode
		hold_nxt = mode_nxt;
		halt_nxt = self_prog && !mode_nxt;
	end

	// A strobe issued last cycle means busy is not yet valid
	function automatic logic wr_or_erase_r();
		wr_or_erase_r = fl_wr || fl_erase_chip || fl_erase_block;
	endfunction : wr_or_erase_r

	// Register the sequencer; reset is driven by the programmer alone
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r         <= S_IDLE;
			op_r            <= 8'h00;
			argn_r          <= 3'h0;
			arg_r           <= 32'h0000_0000;
			end_r           <= 12'h000;
			err_r           <= 1'b0;
			sum_r           <= 16'h0000;
			rbuf_r          <= 24'h00_0000;
			rn_r            <= 2'h0;
			tx_start_r      <= 1'b0;
			tx_data_r       <= 8'h00;
			sec_act_r       <= fpcs_pkg::SEC_RESET;
			prog_mode       <= 1'b0;
			pins_reset_hold <= 1'b0;
			pins_halt       <= 1'b0;
			fl_addr         <= 12'h000;
			fl_wdata        <= 8'h00;
			fl_rd           <= 1'b0;
			fl_wr           <= 1'b0;
			fl_erase_chip   <= 1'b0;
			fl_erase_block  <= 1'b0;
			sec_wr          <= 1'b0;
			sec_wdata       <= fpcs_pkg::SEC_RESET;
		end
		else
		begin
			state_r         <= state_nxt;
			op_r            <= op_nxt;
			argn_r          <= argn_nxt;
			arg_r           <= arg_nxt;
			end_r           <= end_nxt;
			err_r           <= err_nxt;
			sum_r           <= sum_nxt;
			rbuf_r          <= rbuf_nxt;
			rn_r            <= rn_nxt;
			tx_start_r      <= tx_start_nxt;
			tx_data_r       <= tx_data_nxt;
			sec_act_r       <= sec_act_nxt;
			prog_mode       <= mode_nxt;
			pins_reset_hold <= hold_nxt;
			pins_halt       <= halt_nxt;
			fl_addr         <= addr_nxt;
			fl_wdata        <= wdata_nxt;
			fl_rd           <= rd_nxt;
			fl_wr           <= wr_nxt;
			fl_erase_chip   <= ce_nxt;
			fl_erase_block  <= be_nxt;
			sec_wr          <= sw_nxt;
			sec_wdata       <= swd_nxt;
		end
	end

endmodule : fpcs_cmd

`default_nettype wire

// >>> verification/fpcs_cmd_chk.sv
// Property checker for the programming command block
`default_nettype none

module fpcs_cmd_chk (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// Link and mode
	input wire logic        txd_pin,
	input wire logic        self_prog,
	input wire logic        prog_mode,
	input wire logic        pins_reset_hold,
	input wire logic        pins_halt,
	// Flash port
	input wire logic [11:0] fl_addr,
	input wire logic        fl_rd,
	input wire logic        fl_wr,
	input wire logic        fl_erase_chip,
	input wire logic        fl_erase_block,
	// Security store
	input wire logic [2:0]  sec_nv,
	input wire logic        sec_wr,
	input wire logic [2:0]  sec_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0]  sess_r;      // Prohibitions frozen at session entry
	logic [2:0]  sess_nxt;
	logic [11:0] wr_addr_r;   // Address of the last write strobe
	logic [11:0] wr_addr_nxt;

	// Next values of the helper state
	always_comb
	begin
		sess_nxt    = prog_mode ? sess_r : sec_nv;
		wr_addr_nxt = fl_wr ? fl_addr : wr_addr_r;
	end

	// Helper registers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sess_r    <= 3'h0;
			wr_addr_r <= 12'h000;
		end
		else
		begin
			sess_r    <= sess_nxt;
			wr_addr_r <= wr_addr_nxt;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Store after an erase keeps only the chip-erase bit, or all once that is set
	sequence s_store_keep;
		sec_wr && sec_wdata == (sec_nv[fpcs_pkg::SEC_CE] ? sec_nv
			: (sec_nv & fpcs_pkg::SEC_KEEP));
	endsequence
	// Read-back of the address just programmed
	sequence s_readback;
		fl_rd && fl_addr == wr_addr_r;
	endsequence

	AST_PINS_HOLD: assert property (pins_reset_hold == prog_mode)
		else $error("pin hold differs from mode");
	AST_HALT_PINS: assert property ($past(reset_n) |->
		pins_halt == ($past(self_prog) && !prog_mode))
		else $error("halt pin state wrong");
	AST_MODE_KEEP: assert property (!$fell(prog_mode))
		else $error("mode left without reset");
	AST_TX_ORIGIN: assert property ($fell(txd_pin) |-> prog_mode)
		else $error("response outside programming mode");
	AST_START_BIT: assert property ($fell(txd_pin) |-> !txd_pin [*8])
		else $error("start bit too short");
	AST_CE_BLOCK: assert property (fl_erase_chip |-> !sess_r[fpcs_pkg::SEC_CE])
		else $error("chip erase while prohibited");
	AST_BE_BLOCK: assert property (fl_erase_block |-> sess_r == 3'h0)
		else $error("block erase while prohibited");
	AST_WR_BLOCK: assert property (fl_wr |-> !sess_r[fpcs_pkg::SEC_WR])
		else $error("write while prohibited");
	AST_NO_CLEAR: assert property (sec_wr && sec_nv[0] |-> (sec_wdata & sec_nv) == sec_nv)
		else $error("prohibition cleared");
	AST_SEC_SRC: assert property (sec_wr |-> prog_mode)
		else $error("store written outside session");
	AST_CE_CLEARS: assert property (fl_erase_chip |=> ##[0:1000] s_store_keep)
		else $error("erase did not clear prohibitions");
	AST_VERIFY: assert property (fl_wr |=> ##[0:1000] s_readback)
		else $error("write not read back");
endmodule : fpcs_cmd_chk

bind fpcs_cmd fpcs_cmd_chk u_chk (
	.clock(clock), .reset_n(reset_n), .txd_pin(txd_pin), .self_prog(self_prog),
	.prog_mode(prog_mode), .pins_reset_hold(pins_reset_hold), .pins_halt(pins_halt),
	.fl_addr(fl_addr), .fl_rd(fl_rd), .fl_wr(fl_wr), .fl_erase_chip(fl_erase_chip),
	.fl_erase_block(fl_erase_block), .sec_nv(sec_nv), .sec_wr(sec_wr),
	.sec_wdata(sec_wdata)
);

`default_nettype wire

// >>> verification/fpcs_prog_model.sv
// Programmer model: sends command frames, receives responses
`default_nettype none

module fpcs_prog_model (
	// Bit timing reference
	input  wire logic clock,
	// Serial lines
	output var logic  txd,
	input  wire logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int BITC = int'(fpcs_pkg::BIT_CYC) + 1; // Clocks per bit

	initial txd = 1'b1; // Idle line high

	// Only this model starts a transaction: one 8N1 frame, LSB first
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			txd = fr[i];
			repeat (BITC) @(negedge clock);
		end
	endtask : send

	// Receive one frame, sampling mid-bit; unknown if none arrives
	task automatic recv(output logic [7:0] b);
		int n;
		b = 'x;
		n = 0;
		while (rxd === 1'b1 && n < 30000)
		begin
			@(negedge clock);
			n++;
		end
		if (n < 30000)
		begin
			repeat (BITC / 2) @(negedge clock);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BITC) @(negedge clock);
				b[i] = rxd;
			end
			repeat (BITC) @(negedge clock);
		end
	endtask : recv
endmodule : fpcs_prog_model

`default_nettype wire

// >>> verification/fpcs_cmd_bench.sv
// Self-checking bench for the programming command block
`default_nettype none

module fpcs_cmd_bench;
	timeunit 1ns;
	timeprecision 1ns;

	typedef logic [7:0] fpcs_byteq_type [$];
	localparam logic [7:0] ack_b = fpcs_pkg::RSP_ACK;
	localparam logic [7:0] nak_b = fpcs_pkg::RSP_NAK;

	// Device pins
	logic        clock, reset_n, rxd_pin, attach_pin, txd_pin, self_prog;
	logic        prog_mode, pins_reset_hold, pins_halt;
	logic [11:0] fl_addr;
	logic [7:0]  fl_wdata, fl_rdata;
	logic        fl_rd, fl_wr, fl_erase_chip, fl_erase_block, fl_busy, sec_wr;
	logic [2:0]  sec_nv, sec_wdata;
	// Bench state
	logic [7:0]  mem [4096]; // Flash array
	logic [2:0]  busy_cnt;   // Remaining busy cycles
	int          n_mismatch, checks_done, cyc;

	always #25 clock = ~clock;

	fpcs_prog_model u_prog (.clock(clock), .txd(rxd_pin), .rxd(txd_pin));

	fpcs_cmd u_dut (
		.clock(clock), .reset_n(reset_n), .rxd_pin(rxd_pin), .attach_pin(attach_pin),
		.txd_pin(txd_pin), .self_prog(self_prog), .prog_mode(prog_mode),
		.pins_reset_hold(pins_reset_hold), .pins_halt(pins_halt), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .fl_rd(fl_rd), .fl_wr(fl_wr), .fl_erase_chip(fl_erase_chip),
		.fl_erase_block(fl_erase_block), .fl_rdata(fl_rdata), .fl_busy(fl_busy),
		.sec_nv(sec_nv), .sec_wr(sec_wr), .sec_wdata(sec_wdata)
	);

	// Flash and security store: flash programming only clears bits, the store takes the written value
	assign fl_busy = busy_cnt != 3'h0;
	always @(negedge clock)
	begin
		if (fl_wr | fl_erase_chip | fl_erase_block)
			busy_cnt <= 3'h4;
		else if (fl_busy)
			busy_cnt <= busy_cnt - 3'h1;
		if (fl_rd)
			fl_rdata <= mem[fl_addr];
		if (fl_wr)
			mem[fl_addr] <= mem[fl_addr] & fl_wdata;
		if (fl_erase_chip || fl_erase_block)
			for (int i = 0; i < 4096; i++)
				if (fl_erase_chip || (i >> 10) == int'(fl_addr[11:10]))
					mem[i] <= 8'hFF;
		if (sec_wr)
			sec_nv <= sec_wdata;
	end

	// Hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Send a command, compare every response byte
	task automatic xfer(input fpcs_byteq_type tx, input fpcs_byteq_type rx);
		logic [7:0] b;
		// Listen while sending, so an early answer is caught at its start bit
		fork
			foreach (tx[i])
				u_prog.send(tx[i]);
			foreach (rx[i])
			begin
				u_prog.recv(b);
				chk({8'h00, b}, {8'h00, rx[i]});
			end
		join
		repeat (200) @(negedge clock);
	endtask : xfer

	// Reset comes from the programmer side only
	task automatic do_reset;
		@(negedge clock);
		reset_n = 1'b0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
	endtask : do_reset

	// Shipped state: write two bytes, then their checksum
	task automatic t_shipped;
		xfer('{8'h40, 8'h00, 8'h10, 8'h00, 8'h11, 8'hA5, 8'h3C}, '{ack_b});
		chk({15'h0, pins_reset_hold}, 16'h0001);
		xfer('{8'h13, 8'h00, 8'h10, 8'h00, 8'h11}, '{ack_b, 8'h00, 8'hE1});
	endtask : t_shipped

	// Block erase spares other blocks; chip erase leaves array blank
	task automatic t_erase;
		xfer('{8'h22, 8'h01}, '{ack_b});
		chk({8'h00, mem[16]}, 16'h00A5);
		xfer('{8'h20}, '{ack_b});
		xfer('{8'h32}, '{ack_b});
		xfer('{8'h55}, '{nak_b});
	endtask : t_erase

	// Block-erase and write prohibitions, cleared by chip erase
	task automatic t_prot_wr;
		xfer('{8'hA0, 8'h06}, '{ack_b});
		chk({13'h0, sec_nv}, 16'h0006);
		xfer('{8'h22, 8'h00}, '{ack_b});
		do_reset();
		xfer('{8'h22, 8'h00}, '{nak_b});
		xfer('{8'h40, 8'h00, 8'h20, 8'h00, 8'h20}, '{nak_b});
		xfer('{8'h20}, '{ack_b});
		chk({13'h0, sec_nv}, 16'h0000);
	endtask : t_prot_wr

	// Chip-erase prohibition: erases refused, writes still run
	task automatic t_prot_ce;
		xfer('{8'hA0, 8'h01}, '{ack_b});
		do_reset();
		self_prog = 1'b1;
		repeat (3) @(negedge clock);
		chk({15'h0, pins_halt}, 16'h0001);
		self_prog = 1'b0;
		// Bytes sent while not attached are ignored
		attach_pin = 1'b0;
		u_prog.send(8'h20);
		repeat (20) @(negedge clock);
		chk({15'h0, prog_mode}, 16'h0000);
		attach_pin = 1'b1;
		xfer('{8'h20}, '{nak_b});
		xfer('{8'h22, 8'h01}, '{nak_b});
		xfer('{8'h40, 8'h00, 8'h30, 8'h00, 8'h30, 8'h5A}, '{ack_b});
		chk({13'h0, sec_nv}, 16'h0001);
		xfer('{8'hA0, 8'h06}, '{ack_b});
		chk({13'h0, sec_nv}, 16'h0007);
	endtask : t_prot_ce

	task automatic stop_test;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Main sequence
	initial
	begin
		clock = 1'b0;
		reset_n = 1'b0;
		attach_pin = 1'b1;
		self_prog = 1'b0;
		sec_nv = 3'h0;
		busy_cnt = 3'h0;
		fl_rdata = 8'h00;
		foreach (mem[i])
			mem[i] = 8'hFF;
		do_reset();
		t_shipped();
		t_erase();
		t_prot_wr();
		t_prot_ce();
		stop_test();
	end
endmodule : fpcs_cmd_bench

`default_nettype wire
